// ### hdl/rlm_pkg.sv
// Package: constants, register map and encodings of the reference loss monitor
package rlm_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned LOSS_TICK_MS = 100;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * LOSS_TICK_MS;
  localparam int unsigned TICK_W       = 23;

  // ==========================================================================
  // Widths
  localparam int AW    = 8;
  localparam int DW    = 32;
  localparam int LW    = 16;
  localparam int FW    = 6;
  localparam int NTERM = 8;
  localparam int NFUNC = 36;
  localparam int TOW   = 11;

  // ==========================================================================
  // Time-out, in 0.1 s ticks
  localparam logic [TOW-1:0] TIMEOUT_DEF = 11'h00A;
  localparam logic [TOW-1:0] TIMEOUT_MIN = 11'h001;
  localparam logic [TOW-1:0] TIMEOUT_MAX = 11'h4B0;

  // ==========================================================================
  // Register offsets
  localparam logic [AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [AW-1:0] OFS_TIMEOUT  = 8'h04;
  localparam logic [AW-1:0] OFS_VMIN     = 8'h08;
  localparam logic [AW-1:0] OFS_IMIN     = 8'h0C;
  localparam logic [AW-1:0] OFS_PMIN     = 8'h10;
  localparam logic [AW-1:0] OFS_PRESET   = 8'h14;
  localparam logic [AW-1:0] OFS_TERM_LO  = 8'h18;
  localparam logic [AW-1:0] OFS_TERM_HI  = 8'h1C;
  localparam logic [AW-1:0] OFS_STATUS   = 8'h20;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 8'h28;

  // Control field positions
  localparam int CTRL_CRIT_LSB = 0;
  localparam int CTRL_ACT_LSB  = 2;
  localparam int CTRL_SRC_LSB  = 5;

  // Status field positions
  localparam int ST_LOSS_BIT   = 0;
  localparam int ST_VLOSS_BIT  = 1;
  localparam int ST_ILOSS_BIT  = 2;
  localparam int ST_PLOSS_BIT  = 3;
  localparam int ST_TRIP_BIT   = 4;
  localparam int ST_ESTOP_BIT  = 5;
  localparam int ST_JOG_BIT    = 6;
  localparam int ST_STEP_LSB   = 8;
  localparam int ST_INPUT_LSB  = 16;

  // Interrupt bits
  localparam int IRQ_LOSS_BIT  = 0;
  localparam int IRQ_TRIP_BIT  = 1;
  localparam int IRQ_REJ_BIT   = 2;
  localparam int IRQ_W         = 3;

  // ==========================================================================
  // Encodings
  typedef enum logic [2:0] {
    SRC_KEYPAD      = 3'b000,
    SRC_VOLT        = 3'b001,
    SRC_VOLT_SIGNED = 3'b010,
    SRC_CURR        = 3'b011,
    SRC_VOLT_CURR   = 3'b100,
    SRC_PULSE       = 3'b101,
    SRC_OTHER       = 3'b110,
    SRC_RSVD        = 3'b111
  } rlm_src_t;

  typedef enum logic [1:0] {
    CRIT_NONE  = 2'b00,
    CRIT_HALF  = 2'b01,
    CRIT_BELOW = 2'b10,
    CRIT_RSVD  = 2'b11
  } rlm_crit_t;

  typedef enum logic [2:0] {
    ACT_NONE    = 3'b000,
    ACT_COAST   = 3'b001,
    ACT_STOP    = 3'b010,
    ACT_PROTECT = 3'b011,
    ACT_PRESET  = 3'b100
  } rlm_act_t;

  // Terminal function codes
  localparam logic [FW-1:0] FN_SPEED_L    = 6'h00;
  localparam logic [FW-1:0] FN_SPEED_M    = 6'h01;
  localparam logic [FW-1:0] FN_SPEED_H    = 6'h02;
  localparam logic [FW-1:0] FN_ACCEL_SELECT_BIT0     = 6'h03;
  localparam logic [FW-1:0] FN_XCEL_M     = 6'h04;
  localparam logic [FW-1:0] FN_XCEL_H     = 6'h05;
  localparam logic [FW-1:0] FN_DC_BRAKE   = 6'h06;
  localparam logic [FW-1:0] FN_SECOND     = 6'h07;
  localparam logic [FW-1:0] FN_EXCHANGE   = 6'h08;
  localparam logic [FW-1:0] FN_RSVD_A     = 6'h09;
  localparam logic [FW-1:0] FN_UP         = 6'h0A;
  localparam logic [FW-1:0] FN_DOWN       = 6'h0B;
  localparam logic [FW-1:0] FN_THREE_WIRE = 6'h0C;
  localparam logic [FW-1:0] FN_EXT_TRIP   = 6'h0D;
  localparam logic [FW-1:0] FN_RSVD_B     = 6'h0E;
  localparam logic [FW-1:0] FN_ITERM_CLR  = 6'h0F;
  localparam logic [FW-1:0] FN_OPEN_LOOP  = 6'h10;
  localparam logic [FW-1:0] FN_LOC_REM    = 6'h11;
  localparam logic [FW-1:0] FN_ANA_HOLD   = 6'h12;
  localparam logic [FW-1:0] FN_XCEL_STOP  = 6'h13;
  localparam logic [FW-1:0] FN_P_GAIN2    = 6'h14;
  localparam logic [FW-1:0] FN_RSVD_C     = 6'h15;
  localparam logic [FW-1:0] FN_INTERLOCK1 = 6'h16;
  localparam logic [FW-1:0] FN_INTERLOCK2 = 6'h17;
  localparam logic [FW-1:0] FN_INTERLOCK3 = 6'h18;
  localparam logic [FW-1:0] FN_INTERLOCK4 = 6'h19;
  localparam logic [FW-1:0] FN_SPEED_X    = 6'h1A;
  localparam logic [FW-1:0] FN_RESET      = 6'h1B;
  localparam logic [FW-1:0] FN_ESTOP      = 6'h1C;
  localparam logic [FW-1:0] FN_JOG        = 6'h1D;
  localparam logic [FW-1:0] FN_FWD        = 6'h1E;
  localparam logic [FW-1:0] FN_REV        = 6'h1F;
  localparam logic [FW-1:0] FN_ANA_CHANGE = 6'h20;
  localparam logic [FW-1:0] FN_PRE_EXCITE = 6'h21;
  localparam logic [FW-1:0] FN_EXT_PID    = 6'h22;
  localparam logic [FW-1:0] FN_UPDN_CLR   = 6'h23;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]    CTRL_RST   = 8'h00;
  localparam logic [LW-1:0] VMIN_RST   = 16'h0000;
  localparam logic [LW-1:0] IMIN_RST   = 16'h0000;
  localparam logic [LW-1:0] PMIN_RST   = 16'h0000;
  localparam logic [LW-1:0] PRESET_RST = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [NTERM*FW-1:0] TERM_RST = {FN_REV, FN_FWD, FN_JOG, FN_ESTOP,
                                              FN_RESET, FN_SPEED_H, FN_SPEED_M,
                                              FN_SPEED_L};

endpackage : rlm_pkg

// ### hdl/rlm_sync.sv
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module rlm_sync #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : rlm_sync
`default_nettype wire

// ### hdl/rlm_loss_timer.sv
// Persistence timer: declares a loss once a condition outlasts the time-out
`timescale 1ns/1ps
`default_nettype none
module rlm_loss_timer
  import rlm_pkg::*;
#(
  parameter int W = rlm_pkg::TOW
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         enable,
  input  wire logic         below,
  input  wire logic         tick,
  input  wire logic [W-1:0] timeout,
  output logic              lost
);
  logic [W-1:0] cnt_r;
  wire          run = enable & below;
  wire          done = (cnt_r >= timeout);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
      lost  <= 1'b0;
    end else if (!run) begin
      // Recovery above threshold restarts the wait
      cnt_r <= '0; // RULE_18
      lost  <= 1'b0;
    end else begin
      if (tick && !done) begin
        cnt_r <= cnt_r + 1'b1;
      end
      lost <= done; // RULE_06
    end
  end
endmodule : rlm_loss_timer
`default_nettype wire

// ### hdl/rlm_top.sv
// Reference loss monitor with programmable input terminal functions
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (RULE_01) Supervise only voltage, signed voltage, current, voltage+current or pulse sources.
// (RULE_02) Criterion has a disabled choice, which is the reset default.
// (RULE_03) Half criterion: lost when input is below half its minimum point.
// (RULE_04) Below criterion: lost when input is below its minimum point.
// (RULE_05) Voltage+current mode watches voltage only; current loss ignored.
// (RULE_06) Loss declared after time-out, default 1.0 s, range 0.1 to 120 s.
// (RULE_07) Action none: keep running normally after a loss.
// (RULE_08) Action coast: drop output drive at once on loss.
// (RULE_09) Action stop: request deceleration by configured pattern and time.
// (RULE_10) Action protection: raise lost-command trip on loss.
// (RULE_11) Action preset: run at the configured preset frequency on loss.
// (RULE_12) Separate loss indication for voltage, current and pulse sources.
// (RULE_13) Eight terminals, each with its own selector and listed defaults.
// (RULE_14) Emergency stop active rejects every parameter write.
// (RULE_15) Selector list covers all listed functions plus reserved slots.
// (RULE_16) Minimum point is the configured lowest input level per source.
// (RULE_17) Step index from low/mid/high/extra bits; jog overrides.
// (RULE_18) Time-out count restarts when input recovers before expiry.
module rlm_top
  import rlm_pkg::*;
#(
  parameter int unsigned TICK_CNT = rlm_pkg::TICK_CYCLES
) (
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  input  wire logic [rlm_pkg::AW-1:0]   reg_addr,
  input  wire logic [rlm_pkg::DW-1:0]   reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [rlm_pkg::DW-1:0]   reg_rdata,
  input  wire logic [rlm_pkg::LW-1:0]   voltage_ref_input,
  input  wire logic [rlm_pkg::LW-1:0]   current_ref_input,
  input  wire logic [rlm_pkg::LW-1:0]   pulse_ref_input,
  input  wire logic [rlm_pkg::NTERM-1:0] prog_inputs,
  output logic                          irq,
  output logic                          drive_enable,
  output logic                          decel_request,
  output logic                          lost_cmd_trip,
  output logic                          preset_run,
  output logic      [rlm_pkg::LW-1:0]   preset_freq,
  output logic                          voltage_loss_indication,
  output logic                          current_loss_indication,
  output logic                          pulse_loss_indication,
  output logic      [3:0]               step_select,
  output logic                          jog_active,
  output logic      [rlm_pkg::NFUNC-1:0] func_active
);
  import rlm_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic [LW-1:0] threshold(input logic [LW-1:0] min_pt,
                                              input logic [1:0]    crit);
    logic [LW-1:0] t;
    t = '0;
    if (crit == CRIT_HALF) begin
      t = {1'b0, min_pt[LW-1:1]}; // RULE_03
    end else if (crit == CRIT_BELOW) begin
      t = min_pt; // RULE_04
    end
    return t;
  endfunction : threshold

  function automatic logic [LW-1:0] magnitude(input logic [LW-1:0] v);
    return v[LW-1] ? LW'(~v + 1'b1) : v;
  endfunction : magnitude

  function automatic logic [TOW-1:0] clamp_to(input logic [DW-1:0] v);
    logic [TOW-1:0] r;
    r = TIMEOUT_MAX;
    if (v < DW'(TIMEOUT_MIN)) begin
      r = TIMEOUT_MIN;
    end else if (v < DW'(TIMEOUT_MAX)) begin
      r = v[TOW-1:0];
    end
    return r;
  endfunction : clamp_to

  // ==========================================================================
  // Configuration registers
  logic [7:0]          ctrl_r;
  logic [TOW-1:0]      timeout_r;
  logic [LW-1:0]       vmin_r;
  logic [LW-1:0]       imin_r;
  logic [LW-1:0]       pmin_r;
  logic [LW-1:0]       preset_r;
  logic [NTERM*FW-1:0] term_r;
  logic [IRQ_W-1:0]    irq_mask_r;
  logic [IRQ_W-1:0]    irq_stat_r;
  logic [IRQ_W-1:0]    irq_stat_nxt;
  logic [DW-1:0]       rdata_nxt;

  wire [1:0] crit = ctrl_r[CTRL_CRIT_LSB +: 2];
  wire [2:0] act  = ctrl_r[CTRL_ACT_LSB +: 3];
  wire [2:0] src  = ctrl_r[CTRL_SRC_LSB +: 3];

  // ==========================================================================
  // Terminal inputs and function decode
  logic [NTERM-1:0] term_in;
  logic [NFUNC-1:0] func_nxt;

  rlm_sync #(
    .W        (NTERM)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (prog_inputs),
    .sync_out (term_in)
  );

  always_comb begin
    func_nxt = '0;
    for (int t = 0; t < NTERM; t++) begin
      for (int f = 0; f < NFUNC; f++) begin
        // Several terminals may share a function; they OR together
        if (term_r[t*FW +: FW] == FW'(f) && term_in[t]) begin
          func_nxt[f] = 1'b1; // RULE_13 RULE_15
        end
      end
    end
  end

  wire estop_on = func_nxt[FN_ESTOP];
  wire jog_nxt  = func_nxt[FN_JOG];
  wire [3:0] step_nxt = jog_nxt ? 4'h0 :
                        {func_nxt[FN_SPEED_X], func_nxt[FN_SPEED_H],
                         func_nxt[FN_SPEED_M], func_nxt[FN_SPEED_L]}; // RULE_17

  // ==========================================================================
  // Bus decode
  wire wr_ok       = reg_wr & ~estop_on; // RULE_14
  wire wr_rejected = reg_wr & estop_on; // RULE_14
  wire wr_ctrl     = wr_ok && reg_addr == OFS_CTRL;
  wire wr_timeout  = wr_ok && reg_addr == OFS_TIMEOUT;
  wire wr_vmin     = wr_ok && reg_addr == OFS_VMIN;
  wire wr_imin     = wr_ok && reg_addr == OFS_IMIN;
  wire wr_pmin     = wr_ok && reg_addr == OFS_PMIN;
  wire wr_preset   = wr_ok && reg_addr == OFS_PRESET;
  wire wr_term_lo  = wr_ok && reg_addr == OFS_TERM_LO;
  wire wr_term_hi  = wr_ok && reg_addr == OFS_TERM_HI;
  wire wr_mask     = wr_ok && reg_addr == OFS_IRQ_MASK;
  wire rd_irq      = reg_rd && reg_addr == OFS_IRQ_STAT;

  // Each terminal selector sits in its own byte, 6 bits used
  function automatic logic [4*FW-1:0] pack4(input logic [DW-1:0] w);
    return {w[24 +: FW], w[16 +: FW], w[8 +: FW], w[0 +: FW]};
  endfunction : pack4

  function automatic logic [DW-1:0] unpack4(input logic [4*FW-1:0] s);
    return {2'b00, s[3*FW +: FW], 2'b00, s[2*FW +: FW],
            2'b00, s[FW +: FW], 2'b00, s[0 +: FW]};
  endfunction : unpack4

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_r     <= CTRL_RST; // RULE_02
      timeout_r  <= TIMEOUT_DEF;
      vmin_r     <= VMIN_RST;
      imin_r     <= IMIN_RST;
      pmin_r     <= PMIN_RST;
      preset_r   <= PRESET_RST;
      term_r     <= TERM_RST; // RULE_13
      irq_mask_r <= IRQ_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata[7:0];
      end
      if (wr_timeout) begin
        // Out-of-range writes land on the nearest legal time-out
        timeout_r <= clamp_to(reg_wdata); // RULE_06
      end
      if (wr_vmin) begin
        vmin_r <= reg_wdata[LW-1:0]; // RULE_16
      end
      if (wr_imin) begin
        imin_r <= reg_wdata[LW-1:0];
      end
      if (wr_pmin) begin
        pmin_r <= reg_wdata[LW-1:0];
      end
      if (wr_preset) begin
        preset_r <= reg_wdata[LW-1:0];
      end
      if (wr_term_lo) begin
        term_r[0 +: 4*FW] <= pack4(reg_wdata);
      end
      if (wr_term_hi) begin
        term_r[4*FW +: 4*FW] <= pack4(reg_wdata);
      end
      if (wr_mask) begin
        irq_mask_r <= reg_wdata[IRQ_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Loss detection
  logic tick_r;
  logic [TICK_W-1:0] tick_cnt_r;
  logic v_lost;
  logic i_lost;
  logic p_lost;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == TICK_W'(TICK_CNT - 1)) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r     <= 1'b0;
    end
  end

  wire crit_on = (crit == CRIT_HALF) || (crit == CRIT_BELOW); // RULE_02
  // Voltage+current keeps the voltage as main source
  wire v_mon = crit_on && (src == SRC_VOLT || src == SRC_VOLT_SIGNED ||
                           src == SRC_VOLT_CURR); // RULE_01 RULE_05
  wire i_mon = crit_on && (src == SRC_CURR); // RULE_01 RULE_05
  wire p_mon = crit_on && (src == SRC_PULSE); // RULE_01

  // Signed mode compares the magnitude, so a negative command is a loss only when its size is below the threshold
  wire [LW-1:0] v_level = (src == SRC_VOLT_SIGNED) ? magnitude(voltage_ref_input)
                                                   : voltage_ref_input;
  wire v_below = v_level < threshold(vmin_r, crit);
  wire i_below = current_ref_input < threshold(imin_r, crit);
  wire p_below = pulse_ref_input < threshold(pmin_r, crit);

  rlm_loss_timer #(
    .W        (TOW)
  ) u_vtimer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .enable   (v_mon),
    .below    (v_below),
    .tick     (tick_r),
    .timeout  (timeout_r),
    .lost     (v_lost)
  );

  rlm_loss_timer #(
    .W        (TOW)
  ) u_itimer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .enable   (i_mon),
    .below    (i_below),
    .tick     (tick_r),
    .timeout  (timeout_r),
    .lost     (i_lost)
  );

  rlm_loss_timer #(
    .W        (TOW)
  ) u_ptimer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .enable   (p_mon),
    .below    (p_below),
    .tick     (tick_r),
    .timeout  (timeout_r),
    .lost     (p_lost)
  );

  wire loss_any = v_lost | i_lost | p_lost;

  // ==========================================================================
  // Loss action
  logic trip_r;
  logic loss_d_r;
  wire  trip_set  = loss_any && act == ACT_PROTECT; // RULE_10
  // Trip holds until a fault-reset terminal clears it; a new loss wins
  wire  trip_nxt  = trip_set | (trip_r & ~func_nxt[FN_RESET]);
  wire  loss_rise = loss_any & ~loss_d_r;
  wire  trip_rise = trip_set & ~trip_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      trip_r        <= 1'b0;
      loss_d_r      <= 1'b0;
      drive_enable  <= 1'b1;
      decel_request <= 1'b0;
      lost_cmd_trip <= 1'b0;
      preset_run    <= 1'b0;
    end else begin
      trip_r        <= trip_nxt;
      loss_d_r      <= loss_any;
      // Action none leaves every output as it was
      drive_enable  <= ~(loss_any && act == ACT_COAST) & ~trip_nxt; // RULE_07 RULE_08
      decel_request <= loss_any && act == ACT_STOP; // RULE_09
      lost_cmd_trip <= trip_nxt; // RULE_10
      preset_run    <= loss_any && act == ACT_PRESET; // RULE_11
    end
  end

  // ==========================================================================
  // Indications and terminal outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      voltage_loss_indication <= 1'b0;
      current_loss_indication <= 1'b0;
      pulse_loss_indication   <= 1'b0;
      preset_freq             <= PRESET_RST;
      step_select             <= 4'h0;
      jog_active              <= 1'b0;
      func_active             <= '0;
    end else begin
      voltage_loss_indication <= v_lost; // RULE_12
      current_loss_indication <= i_lost; // RULE_12
      pulse_loss_indication   <= p_lost; // RULE_12
      preset_freq             <= preset_r; // RULE_11
      step_select             <= step_nxt; // RULE_17
      jog_active              <= jog_nxt; // RULE_17
      func_active             <= func_nxt;
    end
  end

  // ==========================================================================
  // Interrupts and read-back
  wire [IRQ_W-1:0] irq_events = {wr_rejected, trip_rise, loss_rise};

  // A new event in the read cycle survives the clear
  assign irq_stat_nxt = (rd_irq ? '0 : irq_stat_r) | irq_events;

  wire [DW-1:0] status_word = DW'({term_in, 4'h0, step_select, 1'b0, jog_active,
                                   estop_on, trip_r, p_lost, i_lost, v_lost,
                                   loss_any});

  always_comb begin
    unique case (reg_addr)
      OFS_CTRL:     rdata_nxt = DW'(ctrl_r);
      OFS_TIMEOUT:  rdata_nxt = DW'(timeout_r);
      OFS_VMIN:     rdata_nxt = DW'(vmin_r);
      OFS_IMIN:     rdata_nxt = DW'(imin_r);
      OFS_PMIN:     rdata_nxt = DW'(pmin_r);
      OFS_PRESET:   rdata_nxt = DW'(preset_r);
      OFS_TERM_LO:  rdata_nxt = unpack4(term_r[0 +: 4*FW]);
      OFS_TERM_HI:  rdata_nxt = unpack4(term_r[4*FW +: 4*FW]);
      OFS_STATUS:   rdata_nxt = status_word;
      OFS_IRQ_STAT: rdata_nxt = DW'(irq_stat_r);
      OFS_IRQ_MASK: rdata_nxt = DW'(irq_mask_r);
      default:      rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_stat_r <= '0;
      irq        <= 1'b0;
      reg_rdata  <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq        <= |(irq_stat_nxt & irq_mask_r);
      reg_rdata  <= reg_rd ? rdata_nxt : '0;
    end
  end

endmodule : rlm_top
`default_nettype wire

// ### bench/rlm_monitor.sv
// Port-level checker of the loss monitor
`timescale 1ns/1ps
`default_nettype none
module rlm_monitor
  import rlm_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire logic              reg_rd,
  input wire logic [DW-1:0]     reg_rdata,
  input wire logic              irq,
  input wire logic              drive_enable,
  input wire logic              decel_request,
  input wire logic              lost_cmd_trip,
  input wire logic              preset_run,
  input wire logic              voltage_loss_indication,
  input wire logic              current_loss_indication,
  input wire logic              pulse_loss_indication,
  input wire logic [3:0]        step_select,
  input wire logic              jog_active,
  input wire logic [NFUNC-1:0]  func_active
);
  // ==========================================================================
  // Properties
  wire [2:0] ind3 = {voltage_loss_indication, current_loss_indication, pulse_loss_indication};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_idle_cycle;
    !reg_rd ##1 1'b1;
  endsequence
  a_rdata_idle: assert property (s_idle_cycle |-> reg_rdata == '0)
    else $error("read data not idle");
  a_reset_outputs: assert property (disable iff (1'b0) sys_rst |=> drive_enable && !irq
    && !lost_cmd_trip && ind3 == 3'h0) else $error("outputs not at reset values");
  a_ind_onehot: assert property ($onehot0(ind3))
    else $error("more than one source lost");
  a_trip_no_drive: assert property (lost_cmd_trip |-> !drive_enable)
    else $error("drive on while tripped");
  a_coast_cause: assert property ($fell(drive_enable) |-> ind3 != 3'h0 || lost_cmd_trip)
    else $error("drive dropped without loss");
  a_decel_cause: assert property (decel_request |-> ind3 != 3'h0 && !preset_run)
    else $error("decel without loss");
  a_preset_cause: assert property (preset_run |-> ind3 != 3'h0 && drive_enable)
    else $error("preset run without loss");
  a_jog_step: assert property (jog_active |-> step_select == 4'h0 && func_active[FN_JOG])
    else $error("jog does not override step");
  a_step_bits: assert property (!jog_active |-> step_select == {func_active[FN_SPEED_X],
    func_active[FN_SPEED_H], func_active[FN_SPEED_M], func_active[FN_SPEED_L]})
    else $error("step select mismatch");
endmodule : rlm_monitor
bind rlm_top rlm_monitor u_mon (.*);
`default_nettype wire

// ### bench/rlm_ref_src.sv
// Speed-reference source model: one chosen input sags
`timescale 1ns/1ps
`default_nettype none
module rlm_ref_src (
  input  wire logic        core_clk,
  input  wire logic [1:0]  low_sel,
  input  wire logic [15:0] low_lvl,
  output logic      [15:0] voltage_ref_input,
  output logic      [15:0] current_ref_input,
  output logic      [15:0] pulse_ref_input
);
  // Healthy level far above every minimum point
  always_ff @(posedge core_clk) begin
    voltage_ref_input <= (low_sel == 2'h1) ? low_lvl : 16'h03E8;
    current_ref_input <= (low_sel == 2'h2) ? low_lvl : 16'h03E8;
    pulse_ref_input   <= (low_sel == 2'h3) ? low_lvl : 16'h03E8;
  end
endmodule : rlm_ref_src
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench of the reference loss monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rlm_pkg::*;
  logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic [AW-1:0] reg_addr = '0;
  logic [DW-1:0] reg_wdata = '0, reg_rdata, eq[$];
  logic [LW-1:0] voltage_ref_input, current_ref_input, pulse_ref_input, preset_freq;
  logic [LW-1:0] low_lvl = '0, p;
  logic [NTERM-1:0] prog_inputs = '0, r;
  logic [NFUNC-1:0] func_active;
  logic [3:0] step_select;
  logic [1:0] low_sel = '0;
  logic irq, drive_enable, decel_request, lost_cmd_trip, preset_run, jog_active;
  logic voltage_loss_indication, current_loss_indication, pulse_loss_indication;
  wire [2:0] ind_q = {voltage_loss_indication, current_loss_indication, pulse_loss_indication};
  int miscompares = 0, tests_run = 0;
  always #10 core_clk = ~core_clk;
  rlm_top #(.TICK_CNT(4)) dut (.*);
  rlm_ref_src src (.*);
  // ==========================================================================
  // Tasks
  task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
    tests_run++;
    if (exp !== got) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(logic [AW-1:0] a, logic [DW-1:0] e);
    eq.push_back(e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(posedge core_clk);
  endtask : rd
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic loss_case(logic [2:0] s, logic [1:0] c, logic [2:0] a, logic [1:0] sel,
                           logic [15:0] lvl, logic [2:0] ind);
    low_sel <= sel;
    low_lvl <= lvl;
    wr(OFS_CTRL, {24'h0, s, a, c});
    cyc(20);
    chk("indication", ind, ind_q);
    chk("drive", !(|ind && (a == ACT_COAST || a == ACT_PROTECT)), drive_enable);
    chk("decel", |ind && a == ACT_STOP, decel_request);
    chk("trip", |ind && a == ACT_PROTECT, lost_cmd_trip);
    chk("preset", |ind && a == ACT_PRESET, preset_run);
    chk("irq", |ind, irq);
    low_sel <= 2'h0;
    wr(OFS_CTRL, 32'h0);
    prog_inputs <= 8'h08;
    cyc(6);
    prog_inputs <= 8'h00;
    rd(OFS_IRQ_STAT, {30'h0, |ind && a == ACT_PROTECT, |ind});
    cyc(4);
    chk("irq clear", 1'b0, irq);
  endtask : loss_case
  // Read data judged a cycle after its strobe
  always @(posedge core_clk) begin
    if (rd_d) chk("read data", eq.pop_front(), reg_rdata);
    rd_d <= reg_rd;
  end
  // ==========================================================================
  // Sequence
  initial begin
    void'($urandom(32'h7BF5));
    cyc(8);
    sys_rst <= 1'b0;
    cyc(1);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_TIMEOUT, 32'h0000000A);
    rd(OFS_TERM_LO, 32'h1B020100);
    rd(OFS_TERM_HI, 32'h1F1E1D1C);
    rd(8'h2C, 32'h0);
    wr(OFS_TIMEOUT, 32'h0);
    rd(OFS_TIMEOUT, 32'h1);
    wr(OFS_TIMEOUT, 32'h7FF);
    rd(OFS_TIMEOUT, 32'h4B0);
    p = 16'($urandom_range(1, 1200));
    wr(OFS_TIMEOUT, {16'h0, p});
    rd(OFS_TIMEOUT, {16'h0, p});
    wr(OFS_TIMEOUT, 32'h1);
    for (int k = 0; k < 3; k++) wr(8'(OFS_VMIN + 4 * k), 32'h64);
    p = 16'($urandom_range(1, 16'hFFFF));
    wr(OFS_PRESET, {16'h0, p});
    cyc(1);
    chk("preset freq", p, preset_freq);
    wr(OFS_IRQ_MASK, 32'h1);
    for (int k = 0; k < 5; k++) loss_case(3'h1, 2'h2, k[2:0], 2'h1, 16'h003C, 3'h4);
    loss_case(3'h1, 2'h1, 3'h0, 2'h1, 16'h003C, 3'h0);
    loss_case(3'h2, 2'h1, 3'h2, 2'h1, 16'h0028, 3'h4);
    loss_case(3'h3, 2'h2, 3'h3, 2'h2, 16'h003C, 3'h2);
    loss_case(3'h5, 2'h1, 3'h4, 2'h3, 16'h0028, 3'h1);
    loss_case(3'h4, 2'h2, 3'h1, 2'h2, 16'h0000, 3'h0);
    loss_case(3'h4, 2'h2, 3'h1, 2'h1, 16'h0000, 3'h4);
    loss_case(3'h0, 2'h2, 3'h1, 2'h1, 16'h0000, 3'h0);
    loss_case(3'h1, 2'h0, 3'h1, 2'h1, 16'h0000, 3'h0);
    prog_inputs <= 8'h10;
    cyc(4);
    wr(OFS_TIMEOUT, 32'h7);
    prog_inputs <= 8'h00;
    cyc(4);
    rd(OFS_TIMEOUT, 32'h1);
    rd(OFS_IRQ_STAT, 32'h4);
    r = 8'($urandom_range(1, 7));
    prog_inputs <= r;
    cyc(4);
    chk("step", r[3:0], step_select);
    prog_inputs <= r | 8'h20;
    cyc(4);
    chk("jog step", 5'h10, {jog_active, step_select});
    prog_inputs <= 8'h00;
    cyc(4);
    // Terminal one walks every function code
    for (int f = 0; f < NFUNC; f++) begin
      wr(OFS_TERM_LO, {24'h1B0201, 2'h0, f[5:0]});
      prog_inputs <= 8'h01;
      cyc(4);
      chk("function", 64'h1 << f, func_active);
      prog_inputs <= 8'h00;
      cyc(4);
    end
    cyc(4);
    complete_run();
  end
  initial begin
    cyc(20000);
    miscompares++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
